// ===== rtl/pin_sync3.sv
// three-stage synchroniser with agreement filter for one pin
// assumes clk domain, reset already synchronised
`timescale 1ns/1ps

module pin_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin
  input  wire logic pin,
  // filtered level
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lv;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // change counts only when the second and third stages agree
    if (st_q.s2 == st_q.s3) begin
      st_d.lv = st_q.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lv;

endmodule : pin_sync3

// ===== rtl/quad_dac_channel_loader.sv
// host-written loader for four 10-bit converter channel buffers
// assumes host write strobe is synchronous to clk; power and start pins are not
`timescale 1ns/1ps
`include "quad_dac_consts.svh"

// Operation
// RULE1: a 16-bit word splits into channel select and value bits 13..4
// RULE2: bits 15..14 pick channel 0 to 3 directly
// RULE3: words 000000, 020000, 037760 give zero, half, full minus one step
// RULE4: four independent 10-bit buffers each keep their last written value
// RULE5: channel and value are taken together in one write
// RULE6: host supplies a valid channel in every word
// RULE7: host waits settling time, up to 35 us, between conversions
// RULE8: while host power is low, loading is blocked
// RULE9: backup strap keeps buffers on power restore; normal strap clears them
// RULE10: only the selected channel buffer changes on a write
module quad_dac_channel_loader (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // host write port
  input  wire logic                     wr_stb,
  input  wire logic [`WORD_W-1:0]       digital_input_word,
  // system power signals, asynchronous pins
  input  wire logic                     power_low,
  input  wire logic                     start_restore,
  // straps
  input  wire quad_dac_pkg::strap_t     straps,
  // converter inputs
  output quad_dac_pkg::dac_val_t        dac_out [`NUM_CH],
  output logic                          load_enable
);

  // power starts in hold so no write lands in the first cycle after reset release
  typedef struct packed {
    logic                          start_prev;
    quad_dac_pkg::pwr_state_t      pwr;
    quad_dac_pkg::dac_val_t [3:0]  buf_val;
  } loader_state_t;

  // state
  loader_state_t              st_q;
  loader_state_t              st_d;
  // reset release chain stands apart: it runs on the raw reset, the rest on its copy
  logic [1:0]                 rst_sync_q;
  logic                       rst_int_n;

  // synchronised pins
  logic                       pwr_low_s;
  logic                       start_s;
  logic                       backup_s;
  logic                       normal_s;

  // decoded host write and restore
  logic                       backup_now;
  logic                       start_rise;
  logic                       wr_take;
  logic                       restore_clr;
  logic [`NUM_CH-1:0]         ch_wr;
  quad_dac_pkg::dac_cmd_t     cmd;

  function automatic quad_dac_pkg::dac_cmd_t split_word(
    input logic [`WORD_W-1:0] w
  );
    quad_dac_pkg::dac_cmd_t c;
    c.chan  = w[`SEL_HI:`SEL_LO]; // RULE2
    c.value = w[`VAL_HI:`VAL_LO]; // RULE1 RULE3
    return c;
  endfunction : split_word

  // true when a select code addresses channel idx
  function automatic logic chan_hit(
    input logic [1:0]  sel,
    input int unsigned idx
  );
    logic hit;
    hit = (sel == idx[1:0]);
    return hit;
  endfunction : chan_hit

  // both straps or neither fall back to normal, so a missing strap still clears
  function automatic logic backup_sel(
    input logic bk,
    input logic nm
  );
    logic sel;
    sel = bk & ~nm;
    return sel;
  endfunction : backup_sel

  // an upset code parks in hold, the safe side for the buffers
  function automatic quad_dac_pkg::pwr_state_t next_pwr(
    input quad_dac_pkg::pwr_state_t cur,
    input logic                     low
  );
    quad_dac_pkg::pwr_state_t nx;
    nx = cur;
    unique case (cur)
      quad_dac_pkg::ST_IDLE: begin
        // any low report drops the load signal
        if (low) begin
          nx = quad_dac_pkg::ST_HOLD;
        end
      end
      quad_dac_pkg::ST_HOLD: begin
        // leave hold only once the filtered level is low again
        if (!low) begin
          nx = quad_dac_pkg::ST_IDLE;
        end
      end
      default: begin
        nx = quad_dac_pkg::ST_HOLD;
      end
    endcase
    return nx;
  endfunction : next_pwr

  // next contents of one buffer: clear beats load, load beats hold
  function automatic quad_dac_pkg::dac_val_t buf_next(
    input quad_dac_pkg::dac_val_t cur,
    input logic                   load,
    input logic                   clr,
    input quad_dac_pkg::dac_val_t val
  );
    quad_dac_pkg::dac_val_t nx;
    nx = cur;
    if (load) begin
      nx = val;
    end
    if (clr) begin
      nx = `BUF_RESET;
    end
    return nx;
  endfunction : buf_next

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_q[1];

  // both power pins share the agreement filter against glitches
  pin_sync3 u_sync_pwr (
    .clk   (clk),
    .rst_n (rst_int_n),
    .pin   (power_low),
    .level (pwr_low_s)
  );

  pin_sync3 u_sync_start (
    .clk   (clk),
    .rst_n (rst_int_n),
    .pin   (start_restore),
    .level (start_s)
  );

  // straps are pins too; same latency as start, so mode and edge arrive together
  pin_sync3 u_sync_backup (
    .clk   (clk),
    .rst_n (rst_int_n),
    .pin   (straps.backup_supply_strap),
    .level (backup_s)
  );

  pin_sync3 u_sync_normal (
    .clk   (clk),
    .rst_n (rst_int_n),
    .pin   (straps.normal_power_strap),
    .level (normal_s)
  );

  assign cmd         = split_word(digital_input_word);
  assign backup_now  = backup_sel(backup_s, normal_s);
  assign wr_take     = wr_stb && load_enable; // RULE5 RULE8
  // a start level already high at release counts as an edge once filters settle
  assign start_rise  = start_s && !st_q.start_prev;
  assign restore_clr = start_rise && !backup_now; // RULE9

  // per-channel load strobes; only the addressed buffer ever sees one
  for (genvar i = 0; i < `NUM_CH; i++) begin : g_wr
    assign ch_wr[i] = wr_take && chan_hit(cmd.chan, i); // RULE10
  end

  always_comb begin
    st_d            = st_q;
    st_d.start_prev = start_s;
    st_d.pwr        = next_pwr(st_q.pwr, pwr_low_s);
    // clear wins over a coincident write
    for (int i = 0; i < `NUM_CH; i++) begin
      st_d.buf_val[i] = buf_next(st_q.buf_val[i], ch_wr[i], restore_clr, cmd.value); // RULE4
    end
  end

  // the one state register, reset by the released copy
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_q.start_prev <= 1'b0;
      st_q.pwr        <= quad_dac_pkg::ST_HOLD;
      st_q.buf_val    <= {`NUM_CH{`BUF_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  // load is blocked in the same cycle power_low is seen, not a cycle later
  assign load_enable = (st_q.pwr == quad_dac_pkg::ST_IDLE) && !pwr_low_s; // RULE8

  // outputs come straight from the buffer flops
  for (genvar i = 0; i < `NUM_CH; i++) begin : g_out
    assign dac_out[i] = st_q.buf_val[i];
  end

endmodule : quad_dac_channel_loader

// ===== rtl/quad_dac_consts.svh
// constants for the four-channel converter loader
// assumes inclusion by bare name from rtl files
`ifndef QUAD_DAC_CONSTS_SVH
`define QUAD_DAC_CONSTS_SVH

`define WORD_W          16
`define VAL_W           10
`define SEL_HI          15
`define SEL_LO          14
`define VAL_HI          13
`define VAL_LO          4
`define NUM_CH          4
`define BUF_RESET       10'h000
`define SETTLE_NS       35000
`define CLK_NS          20
`define SETTLE_CYC      ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== rtl/quad_dac_pkg.sv
// types for the four-channel converter loader
// assumes nothing beyond the constants header
`include "quad_dac_consts.svh"

package quad_dac_pkg;

  typedef logic [`VAL_W-1:0] dac_val_t;

  typedef struct packed {
    logic [1:0] chan;
    dac_val_t   value;
  } dac_cmd_t;

  typedef struct packed {
    logic backup_supply_strap;
    logic normal_power_strap;
  } strap_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } pwr_state_t;

endpackage : quad_dac_pkg

// ===== test/host_writer.sv
// host model issuing paced one-word writes
// assumes the loader samples on rising clk
`timescale 1ns/1ps
`include "quad_dac_consts.svh"
module host_writer (
  // clock
  input wire logic clk,
  // write port
  output logic wr_stb,
  output logic [`WORD_W-1:0] digital_input_word
);
  initial begin
    wr_stb = 1'b0;
    digital_input_word = 16'h0;
  end
  task automatic put(input logic [1:0] c, input logic [9:0] v, input int gap);
    @(posedge clk);
    wr_stb <= 1'b1;
    digital_input_word <= {c, v, 4'hA};
    @(posedge clk);
    wr_stb <= 1'b0;
    digital_input_word <= ~{c, v, 4'hA};
    repeat (gap) @(posedge clk);
  endtask : put
endmodule : host_writer

// ===== test/quad_dac_channel_loader_asserts.sv
// port checker for the loader
// assumes bind onto every loader instance
`timescale 1ns/1ps
`include "quad_dac_consts.svh"
module quad_dac_channel_loader_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host and pins
  input wire logic wr_stb,
  input wire logic [`WORD_W-1:0] digital_input_word,
  input wire logic power_low,
  input wire logic start_restore,
  input wire quad_dac_pkg::strap_t straps,
  // outputs
  input wire quad_dac_pkg::dac_val_t dac_out [`NUM_CH],
  input wire logic load_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic wr = wr_stb && load_enable;
  wire logic [1:0] sel = digital_input_word[15:14];
  wire logic [9:0] val = digital_input_word[13:4];
  property p_value; wr |=> dac_out[$past(sel)] == $past(val); endproperty
  a_value: assert property (p_value)
    else $error("value");
  property p_chan; wr && sel == 2'h3 |=> dac_out[3] == $past(val); endproperty
  a_chan: assert property (p_chan)
    else $error("chan");
  property p_half; wr && val == 10'h200 |=> dac_out[$past(sel)] == 10'h200; endproperty
  a_half: assert property (p_half)
    else $error("half");
  property p_keep1; $changed(dac_out[1]) |-> $past(wr) || dac_out[1] == 10'h0; endproperty
  a_keep1: assert property (p_keep1)
    else $error("keep1");
  property p_other; wr && sel != 2'h2 |=> $stable(dac_out[2]); endproperty
  a_other: assert property (p_other)
    else $error("other");
  property p_pwr; power_low [*5] |-> !load_enable; endproperty
  a_pwr: assert property (p_pwr)
    else $error("pwr");
  property p_bk; straps == 2'h2 && !wr |=> $stable(dac_out[0]); endproperty
  a_bk: assert property (p_bk)
    else $error("bk");
  property p_clr; straps != 2'h2 && $rose(start_restore) |-> ##[1:8] dac_out[0] == 10'h0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clr");
endmodule : quad_dac_channel_loader_asserts
bind quad_dac_channel_loader quad_dac_channel_loader_asserts chk (.*);

// ===== test/quad_dac_channel_loader_tb.sv
// self-checking bench for the loader
// assumes host model and checker compiled first
`timescale 1ns/1ps
`include "quad_dac_consts.svh"
module quad_dac_channel_loader_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_low = 1'b0;
  logic start_restore = 1'b0;
  quad_dac_pkg::strap_t straps = 2'h1;
  logic wr_stb;
  logic [`WORD_W-1:0] digital_input_word;
  logic load_enable;
  quad_dac_pkg::dac_val_t dac_out [`NUM_CH];
  quad_dac_pkg::dac_val_t ev [`NUM_CH];
  int n_mismatch = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  host_writer hw (.*);
  quad_dac_channel_loader dut (.*);
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic all_chk();
    for (int i = 0; i < 4; i++) chk("dac_out", ev[i], dac_out[i]);
  endtask : all_chk
  task automatic boot(input logic [1:0] s);
    straps <= s;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    ev = '{default: 10'h0};
    chk("load_enable", 10'h1, {9'h0, load_enable});
  endtask : boot
  task automatic t_codes();
    logic [9:0] v [4] = '{10'h000, 10'h200, 10'h3FF, 10'h155};
    for (int c = 0; c < 4; c++) begin
      hw.put(c[1:0], v[c], 1750);
      ev[c] = v[c];
      all_chk();
    end
  endtask : t_codes
  task automatic t_power();
    power_low <= 1'b1;
    repeat (8) @(posedge clk);
    chk("load_enable", 10'h0, {9'h0, load_enable});
    hw.put(2'h1, 10'h3C3, 5);
    all_chk();
    power_low <= 1'b0;
    repeat (8) @(posedge clk);
    chk("load_enable", 10'h1, {9'h0, load_enable});
  endtask : t_power
  task automatic t_restore(input logic bk);
    boot(bk ? 2'h2 : 2'h1);
    hw.put(2'h0, 10'h1E1, 5);
    ev[0] = 10'h1E1;
    start_restore <= 1'b1;
    repeat (10) @(posedge clk);
    start_restore <= 1'b0;
    if (!bk) ev[0] = 10'h0;
    all_chk();
  endtask : t_restore
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    boot(2'h1);
    t_codes();
    t_power();
    t_restore(1'b1);
    t_restore(1'b0);
    report_and_stop();
  end
endmodule : quad_dac_channel_loader_tb
